// ===== design/psr_pkg.sv
// package: register map, field positions and reset values of the transceiver register set
package psr_pkg;
   localparam logic [4:0] PSR_ADDR_STATUS = 5'h01;
   localparam logic [4:0] PSR_ADDR_ID_HIGH = 5'h02;
   localparam logic [4:0] PSR_ADDR_ID_LOW = 5'h03;
   localparam logic [4:0] PSR_ADDR_ADVERT = 5'h04;
   // status bit positions
   localparam int PSR_ST_T4 = 15;
   localparam int PSR_ST_CAP_LO = 11;
   localparam int PSR_ST_CAP_HI = 14;
   localparam int PSR_ST_PREAMBLE = 6;
   localparam int PSR_ST_AN_DONE = 5;
   localparam int PSR_ST_FAULT = 4;
   localparam int PSR_ST_AN_ABLE = 3;
   localparam int PSR_ST_LINK = 2;
   localparam int PSR_ST_JABBER = 1;
   localparam int PSR_ST_EXT = 0;
   // advertisement bit positions
   localparam int PSR_AD_NEXT_PAGE = 15;
   localparam int PSR_AD_ACK = 14;
   localparam int PSR_AD_FAULT = 13;
   localparam int PSR_AD_PAUSE = 10;
   localparam int PSR_AD_T4 = 9;
   localparam int PSR_AD_ABIL_LO = 5;
   localparam int PSR_AD_ABIL_HI = 8;
   localparam int PSR_AD_SEL_HI = 4;
   // reset values
   localparam logic [3:0] PSR_ABIL_RESET = 4'hF;
   localparam logic [4:0] PSR_SEL_RESET = 5'h01;
   // identity values, arbitrary
   localparam logic [15:0] PSR_ORG_HIGH_DEF = 16'h1234;
   localparam logic [5:0] PSR_ORG_LOW_DEF = 6'h2A;
   localparam logic [5:0] PSR_MODEL_DEF = 6'h11;
   localparam logic [3:0] PSR_REV_DEF = 4'h7;
   // management access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } psr_req_s;
   // live line-side conditions
   typedef struct packed {
      logic an_done;
      logic remote_fault;
      logic link_up;
      logic jabber;
      logic partner_ack;
   } psr_line_s;
endpackage : psr_pkg

// ===== design/psr_regs.sv
// transceiver status, identifier and advertisement registers
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - status bit 15 four-pair capability is fixed at 0
// - status bits 14 to 11 speed and duplex capabilities are fixed at 1
// - status bit 6 preamble suppression reads 0
// - status bit 5 reads 1 only after auto-negotiation completes
// - status bit 4 latches remote fault, cleared by read or reset
// - auto-negotiation ability bit reads 1
// - status bit 2 link status, latch-low, resets to 0
// - status bit 1 latches jabber high, resets to 0
// - status bit 0 extended capability reads 1
// - identifier high shows organisation id bits 3 to 18
// - identifier low shows org id 19-24, model and revision
// - advertisement bit 15 next page reads 0
// - advertisement bit 14 sets once partner data acknowledged
// - advertisement bit 13 writable fault flag, resets 0
// - advertisement bit 10 writable pause flag, resets 0
// - advertisement bit 9 four-pair support reads 0
// - advertisement bits 8 to 5 writable abilities, reset to 1
// - advertisement bits 4:0 writable selector, resets to 0_0001
module psr_regs #(
   parameter logic [15:0] ORG_HIGH = psr_pkg::PSR_ORG_HIGH_DEF,
   parameter logic [5:0] ORG_LOW = psr_pkg::PSR_ORG_LOW_DEF,
   parameter logic [5:0] MODEL = psr_pkg::PSR_MODEL_DEF,
   parameter logic [3:0] REVISION = psr_pkg::PSR_REV_DEF
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire psr_pkg::psr_req_s req_i,
   input wire psr_pkg::psr_line_s line_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output logic fault_adv_o,
   output logic pause_adv_o,
   output logic [3:0] abil_adv_o,
   output logic [4:0] selector_o
);
   import psr_pkg::*;

   logic fault_lh;
   logic jabber_lh;
   logic link_ll;
   logic an_done;
   logic ack;
   logic [15:0] status_v;
   logic [15:0] advert_v;
   logic [15:0] next_rdata;
   logic rd_status;

   // the indirect pair serialises bytes low first; here a word arrives whole
   assign rd_status = req_i.rd && (req_i.addr == PSR_ADDR_STATUS);

   // latch-high: set wins over clear-on-read
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         fault_lh <= 1'b0;
         jabber_lh <= 1'b0;
      end else if (ce_i) begin
         fault_lh <= line_i.remote_fault | (fault_lh & ~rd_status);
         jabber_lh <= line_i.jabber | (jabber_lh & ~rd_status);
      end
   end

   // latch-low: a drop wins over the read that would restore it
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         link_ll <= 1'b0;
      end else if (ce_i) begin
         if (!line_i.link_up) begin
            link_ll <= 1'b0;
         end else if (rd_status) begin
            link_ll <= 1'b1;
         end
      end
   end

   // completion and acknowledge tracking
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         an_done <= 1'b0;
         ack <= 1'b0;
      end else if (ce_i) begin
         an_done <= line_i.an_done;
         ack <= line_i.partner_ack;
      end
   end

   // writable advertisement fields; other bits ignore writes
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         fault_adv_o <= 1'b0;
         pause_adv_o <= 1'b0;
         abil_adv_o <= PSR_ABIL_RESET;
         selector_o <= PSR_SEL_RESET;
      end else if (ce_i && req_i.wr && req_i.addr == PSR_ADDR_ADVERT) begin
         fault_adv_o <= req_i.wdata[PSR_AD_FAULT];
         pause_adv_o <= req_i.wdata[PSR_AD_PAUSE];
         abil_adv_o <= req_i.wdata[PSR_AD_ABIL_HI:PSR_AD_ABIL_LO];
         selector_o <= req_i.wdata[PSR_AD_SEL_HI:0];
      end
   end

   // read word assembly
   always_comb begin
      status_v = 16'h0000;
      status_v[PSR_ST_T4] = 1'b0;
      status_v[PSR_ST_CAP_HI:PSR_ST_CAP_LO] = 4'hF;
      status_v[PSR_ST_PREAMBLE] = 1'b0;
      status_v[PSR_ST_AN_DONE] = an_done;
      status_v[PSR_ST_FAULT] = fault_lh;
      status_v[PSR_ST_AN_ABLE] = 1'b1;
      status_v[PSR_ST_LINK] = link_ll;
      status_v[PSR_ST_JABBER] = jabber_lh;
      status_v[PSR_ST_EXT] = 1'b1;
      advert_v = 16'h0000;
      advert_v[PSR_AD_NEXT_PAGE] = 1'b0;
      advert_v[PSR_AD_ACK] = ack;
      advert_v[PSR_AD_FAULT] = fault_adv_o;
      advert_v[PSR_AD_PAUSE] = pause_adv_o;
      advert_v[PSR_AD_T4] = 1'b0;
      advert_v[PSR_AD_ABIL_HI:PSR_AD_ABIL_LO] = abil_adv_o;
      advert_v[PSR_AD_SEL_HI:0] = selector_o;
      unique case (req_i.addr)
         PSR_ADDR_STATUS: next_rdata = status_v;
         PSR_ADDR_ID_HIGH: next_rdata = ORG_HIGH;
         PSR_ADDR_ID_LOW: next_rdata = {ORG_LOW, MODEL, REVISION};
         PSR_ADDR_ADVERT: next_rdata = advert_v;
         default: next_rdata = 16'h0000;
      endcase
   end

   // read data register, one cycle after the read strobe
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            rdata_o <= next_rdata;
         end
      end
   end

   // assertions
   property p_fixed_status;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> (rdata_o[15:11] == 5'h0F && rdata_o[6] == 1'b0 && rdata_o[3] && rdata_o[0]);
   endproperty
   a_fixed_status: assert property (p_fixed_status) else $error("fixed status bits wrong");
   property p_cap_bits;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> (rdata_o[14:11] == 4'hF);
   endproperty
   a_cap_bits: assert property (p_cap_bits) else $error("capability bits not set");
   property p_fault_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && line_i.remote_fault) ##1 (ce_i && !rd_status && !line_i.remote_fault) |=> fault_lh;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("remote fault lost before read");
   property p_fault_clear;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status && !line_i.remote_fault) |=> !fault_lh;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("remote fault not cleared by read");
   property p_jabber_latch;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && line_i.jabber) |=> jabber_lh;
   endproperty
   a_jabber_latch: assert property (p_jabber_latch) else $error("jabber not latched");
   property p_link_low;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && !line_i.link_up) ##1 (ce_i && rd_status) |=> (rdata_o[PSR_ST_LINK] == 1'b0);
   endproperty
   a_link_low: assert property (p_link_low) else $error("link drop not reported");
   property p_id_low;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.rd && req_i.addr == PSR_ADDR_ID_LOW) |=> (rdata_o == {ORG_LOW, MODEL, REVISION});
   endproperty
   a_id_low: assert property (p_id_low) else $error("identifier low wrong");
   property p_adv_fixed;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.rd && req_i.addr == PSR_ADDR_ADVERT) |=> (!rdata_o[15] && !rdata_o[9] && rdata_o[12:11] == 2'h0);
   endproperty
   a_adv_fixed: assert property (p_adv_fixed) else $error("advertisement fixed bits wrong");
   property p_adv_write;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.wr && req_i.addr == PSR_ADDR_ADVERT) |=>
         (selector_o == $past(req_i.wdata[4:0]) && abil_adv_o == $past(req_i.wdata[8:5]));
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("advertisement write lost");
   property p_status_nowrite;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.wr && req_i.addr != PSR_ADDR_ADVERT) |=> $stable(selector_o) && $stable(abil_adv_o);
   endproperty
   a_status_nowrite: assert property (p_status_nowrite) else $error("stray write took effect");
   property p_t4_zero;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> !rdata_o[PSR_ST_T4];
   endproperty
   a_t4_zero: assert property (p_t4_zero) else $error("four-pair capability bit set");
   property p_preamble;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> !rdata_o[PSR_ST_PREAMBLE];
   endproperty
   a_preamble: assert property (p_preamble) else $error("preamble suppression bit set");
   property p_an_done;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i ##1 (ce_i && rd_status) |=> (rdata_o[PSR_ST_AN_DONE] == $past(line_i.an_done, 2));
   endproperty
   a_an_done: assert property (p_an_done) else $error("autoneg completion bit wrong");
   property p_an_able;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> rdata_o[PSR_ST_AN_ABLE];
   endproperty
   a_an_able: assert property (p_an_able) else $error("autoneg ability bit clear");
   property p_ext_cap;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status) |=> rdata_o[PSR_ST_EXT];
   endproperty
   a_ext_cap: assert property (p_ext_cap) else $error("extended capability bit clear");
   property p_fault_set;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && line_i.remote_fault) |=> fault_lh;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("remote fault not latched");
   property p_jabber_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (jabber_lh && !(ce_i && rd_status)) |=> jabber_lh;
   endproperty
   a_jabber_hold: assert property (p_jabber_hold) else $error("jabber lost before read");
   property p_jabber_clear;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status && !line_i.jabber) |=> !jabber_lh;
   endproperty
   a_jabber_clear: assert property (p_jabber_clear) else $error("jabber not cleared by read");
   property p_link_drop;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && !line_i.link_up) |=> !link_ll;
   endproperty
   a_link_drop: assert property (p_link_drop) else $error("link drop not latched");
   property p_link_restore;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && rd_status && line_i.link_up) |=> link_ll;
   endproperty
   a_link_restore: assert property (p_link_restore) else $error("link not restored by read");
   property p_id_high;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.rd && req_i.addr == PSR_ADDR_ID_HIGH) |=> (rdata_o == ORG_HIGH);
   endproperty
   a_id_high: assert property (p_id_high) else $error("identifier high wrong");
   property p_ack;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i ##1 (ce_i && req_i.rd && req_i.addr == PSR_ADDR_ADVERT) |=> (rdata_o[PSR_AD_ACK] == $past(line_i.partner_ack, 2));
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge bit wrong");
   property p_fault_adv;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.wr && req_i.addr == PSR_ADDR_ADVERT) |=> (fault_adv_o == $past(req_i.wdata[PSR_AD_FAULT]));
   endproperty
   a_fault_adv: assert property (p_fault_adv) else $error("fault advertisement write lost");
   property p_pause_adv;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.wr && req_i.addr == PSR_ADDR_ADVERT) |=> (pause_adv_o == $past(req_i.wdata[PSR_AD_PAUSE]));
   endproperty
   a_pause_adv: assert property (p_pause_adv) else $error("pause advertisement write lost");
   property p_adv_t4;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && req_i.rd && req_i.addr == PSR_ADDR_ADVERT) |=> !rdata_o[PSR_AD_T4];
   endproperty
   a_adv_t4: assert property (p_adv_t4) else $error("four-pair support advertised");
   property p_reset_values;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> (!fault_adv_o && !pause_adv_o && abil_adv_o == PSR_ABIL_RESET && selector_o == PSR_SEL_RESET);
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("advertisement reset values wrong");
   property p_flags_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !(ce_i && req_i.wr && req_i.addr == PSR_ADDR_ADVERT) |=>
         ($stable(fault_adv_o) && $stable(pause_adv_o) && $stable(abil_adv_o) && $stable(selector_o));
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("advertisement changed without write");
   property p_freeze;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ce_i |=>
         ($stable(rdata_o) && $stable(rvalid_o) && $stable(fault_lh) && $stable(jabber_lh) && $stable(link_ll));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   c_fault_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) fault_lh ##1 rd_status);
   c_link_restore: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) !link_ll ##1 rd_status ##1 link_ll);
   c_adv_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) req_i.wr && req_i.addr == PSR_ADDR_ADVERT);
   c_link_drop_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) !line_i.link_up ##1 rd_status);
   c_frozen_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) !ce_i && req_i.rd);
endmodule : psr_regs
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the transceiver register set
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import psr_pkg::*;
   logic clk_sys_i;
   logic rst_n_i;
   logic ce_i;
   psr_req_s req_i;
   psr_line_s line_i;
   logic [15:0] rdata_o;
   logic rvalid_o;
   logic fault_adv_o;
   logic pause_adv_o;
   logic [3:0] abil_adv_o;
   logic [4:0] selector_o;
   int errors;
   int num_checks;
   psr_regs dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req_i), .line_i(line_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .fault_adv_o(fault_adv_o), .pause_adv_o(pause_adv_o),
      .abil_adv_o(abil_adv_o), .selector_o(selector_o));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [15:0] st(input logic an, input logic f, input logic l, input logic j);
      return 16'h7809 | {10'h000, an, f, 1'b0, l, j, 1'b0};
   endfunction : st
   function automatic logic [15:0] adv_ports();
      return {5'h00, fault_adv_o, pause_adv_o, abil_adv_o, selector_o};
   endfunction : adv_ports
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // one-cycle read strobe, answer awaited for a bounded number of cycles
   task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp, input string what);
      bit seen;
      seen = 1'b0;
      @(negedge clk_sys_i);
      req_i.rd = 1'b1;
      req_i.addr = a;
      for (int i = 0; i < 3 && !seen; i++) begin
         @(negedge clk_sys_i);
         req_i.rd = 1'b0;
         if (rvalid_o === 1'b1) begin
            seen = 1'b1;
            chk({8'h00, rdata_o[7:0]}, {8'h00, exp[7:0]}, what);
            chk({8'h00, rdata_o[15:8]}, {8'h00, exp[15:8]}, what);
         end
      end
      if (!seen) begin
         chk({15'h0000, rvalid_o}, 16'h0001, "no read answer");
         end_of_test();
      end
   endtask : rd_reg
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_sys_i);
      req_i.wr = 1'b1;
      req_i.addr = a;
      req_i.wdata = d;
      @(negedge clk_sys_i);
      req_i.wr = 1'b0;
   endtask : wr_reg
   initial begin
      errors = 0;
      num_checks = 0;
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      req_i = '0;
      line_i = '0;
      repeat (16) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      rd_reg(PSR_ADDR_STATUS, st(0, 0, 0, 0), "status reset");
      rd_reg(PSR_ADDR_ID_HIGH, PSR_ORG_HIGH_DEF, "id high");
      rd_reg(PSR_ADDR_ID_LOW, {PSR_ORG_LOW_DEF, PSR_MODEL_DEF, PSR_REV_DEF}, "id low");
      rd_reg(PSR_ADDR_ADVERT, 16'h01E1, "advert reset");
      chk(adv_ports(), 16'h01E1, "advert outputs reset");
      $display("test reset values done");
      wr_reg(PSR_ADDR_ADVERT, 16'hE7FF);
      chk(adv_ports(), 16'h07FF, "advert outputs set");
      rd_reg(PSR_ADDR_ADVERT, 16'h25FF, "advert set");
      wr_reg(PSR_ADDR_ADVERT, 16'h0000);
      chk(adv_ports(), 16'h0000, "advert outputs clear");
      rd_reg(PSR_ADDR_ADVERT, 16'h0000, "advert clear");
      wr_reg(PSR_ADDR_ADVERT, 16'h01E1);
      wr_reg(PSR_ADDR_STATUS, 16'h8000);
      wr_reg(PSR_ADDR_ID_HIGH, 16'h0000);
      wr_reg(PSR_ADDR_ID_LOW, 16'hFFFF);
      rd_reg(PSR_ADDR_STATUS, st(0, 0, 0, 0), "status after write");
      rd_reg(PSR_ADDR_ID_HIGH, PSR_ORG_HIGH_DEF, "id high after write");
      rd_reg(PSR_ADDR_ID_LOW, {PSR_ORG_LOW_DEF, PSR_MODEL_DEF, PSR_REV_DEF}, "id low after write");
      rd_reg(5'h00, 16'h0000, "unmapped low");
      rd_reg(5'h1F, 16'h0000, "unmapped high");
      @(negedge clk_sys_i);
      ce_i = 1'b0;
      wr_reg(PSR_ADDR_ADVERT, 16'h0000);
      @(negedge clk_sys_i);
      req_i.rd = 1'b1;
      req_i.addr = PSR_ADDR_STATUS;
      @(negedge clk_sys_i);
      req_i.rd = 1'b0;
      chk({15'h0000, rvalid_o}, 16'h0000, "read taken while frozen");
      ce_i = 1'b1;
      chk(adv_ports(), 16'h01E1, "write taken while frozen");
      $display("test write access done");
      line_i.an_done = 1'b1;
      line_i.link_up = 1'b1;
      line_i.partner_ack = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      rd_reg(PSR_ADDR_STATUS, st(1, 0, 0, 0), "link low since reset");
      rd_reg(PSR_ADDR_STATUS, st(1, 0, 1, 0), "link restored");
      rd_reg(PSR_ADDR_ADVERT, 16'h41E1, "partner ack");
      @(negedge clk_sys_i);
      line_i.remote_fault = 1'b1;
      line_i.jabber = 1'b1;
      line_i.link_up = 1'b0;
      @(negedge clk_sys_i);
      line_i.remote_fault = 1'b0;
      line_i.jabber = 1'b0;
      line_i.link_up = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      rd_reg(PSR_ADDR_STATUS, st(1, 1, 0, 1), "latched events");
      rd_reg(PSR_ADDR_STATUS, st(1, 0, 1, 0), "events cleared");
      line_i.link_up = 1'b0;
      rd_reg(PSR_ADDR_STATUS, st(1, 0, 0, 0), "link drop");
      line_i.link_up = 1'b1;
      line_i.an_done = 1'b0;
      line_i.remote_fault = 1'b1;
      line_i.partner_ack = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      line_i.remote_fault = 1'b0;
      rd_reg(PSR_ADDR_STATUS, st(0, 1, 0, 0), "autoneg undone");
      $display("test line events done");
      line_i.jabber = 1'b1;
      wr_reg(PSR_ADDR_ADVERT, 16'h2400);
      chk(adv_ports(), 16'h0600, "advert flags set");
      @(negedge clk_sys_i);
      line_i.jabber = 1'b0;
      rst_n_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      chk(adv_ports(), 16'h01E1, "advert outputs second reset");
      rd_reg(PSR_ADDR_STATUS, st(0, 0, 0, 0), "status second reset");
      rd_reg(PSR_ADDR_ADVERT, 16'h01E1, "advert second reset");
      $display("test second reset done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
